// file: common/prox_consts.svh
/*
 * Register offsets, field positions, reset values and the target address of the
 * proximity result and threshold block. Assumes it is included by its bare name.
 */
`ifndef PROX_CONSTS_SVH
`define PROX_CONSTS_SVH

`define ADDR_FLAGS 8'h8c
`define ADDR_RES_LO 8'h8d
`define ADDR_RES_HI 8'h8e
`define ADDR_IRQ_CTL 8'h8f
`define ADDR_UP_LO 8'h90
`define ADDR_UP_HI 8'h91
`define ADDR_LO_LO 8'h92
`define ADDR_LO_HI 8'h93
`define ADDR_COMP_HI 8'h94
`define ADDR_COMP_LO 8'h95
`define ADDR_FILTER 8'h9e

`define TARGET_ADDR 7'h23

`define BIT_NEW 0
`define BIT_IRQ 1
`define BIT_SAT 7
`define BIT_MODE 0
`define BIT_POL 2
`define FILTER_LSB 4

`define RST_UP 11'h7ff
`define RST_LO 11'h000
`define RST_COMP 10'h000
`define RST_RES 11'h000
`define RST_FILTER 4'h0
`define RUN_MAX 4'hf

`endif

// file: common/prox_pkg.sv
/*
 * Types shared by the serial target and the register block.
 * Assumes nothing of its surroundings.
 */
package prox_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_WRX,
        ST_TX,
        ST_MACK
    } link_state_t;
    typedef logic [10:0] sample_t;
endpackage

// file: common/reg_link_if.sv
/*
 * Register access link between the serial target and the register block.
 * Assumes both ends run on the same system clock.
 */
interface reg_link_if;
    logic [7:0] addr;
    logic wr_stb;
    logic [7:0] wdata;
    logic rd_stb;
    logic [7:0] rdata;
    logic rd_active;
    modport target (output addr, output wr_stb, output wdata, output rd_stb,
                    output rd_active, input rdata);
    modport regs (input addr, input wr_stb, input wdata, input rd_stb,
                  input rd_active, output rdata);
endinterface

// file: hw/twowire_target.sv
/*
 * Two-wire serial bus target: pointer write, data writes with auto increment,
 * and reads with auto increment. Assumes SCL and SDA are asynchronous pins and
 * that the register block answers a read strobe on the next clock edge.
 */
`include "prox_consts.svh"

module twowire_target
    import prox_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    reg_link_if.target link
);
    logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    link_state_t state_q, state_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d, addr_q, addr_d, wdat_q, wdat_d;
    logic [3:0] cnt_q, cnt_d;
    logic rw_q, rw_d, first_q, first_d, oe_q, oe_d, act_q, act_d;
    logic rd_q, rd_d, wr_q, wr_d;
    logic rise, fall, start, stop;

    assign rise = scl_s_q && !scl_p_q;
    assign fall = !scl_s_q && scl_p_q;
    assign start = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
    assign stop = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;

    always_comb begin
        state_d = state_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        rw_d = rw_q;
        first_d = first_q;
        ptr_d = ptr_q;
        oe_d = oe_q;
        act_d = act_q;
        rd_d = 1'b0;
        wr_d = 1'b0;
        wdat_d = wdat_q;
        addr_d = addr_q;
        if (start) begin
            state_d = ST_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
            act_d = 1'b0;
        end else if (stop) begin
            state_d = ST_IDLE;
            oe_d = 1'b0;
            act_d = 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_WRX: begin
                    if (rise) begin
                        sh_d = {sh_q[6:0], sda_s_q};
                        cnt_d = cnt_q + 4'h1;
                    end else if (fall && cnt_q == 4'h8) begin
                        oe_d = 1'b1;
                        state_d = ST_ACK;
                        if (state_q == ST_ADDR) begin
                            if (sh_q[7:1] == `TARGET_ADDR) begin
                                rw_d = sh_q[0];
                                first_d = 1'b1;
                                act_d = sh_q[0];
                                rd_d = sh_q[0];
                                addr_d = ptr_q;
                            end else begin
                                oe_d = 1'b0;
                                state_d = ST_IDLE;
                            end
                        end else if (first_q) begin
                            ptr_d = sh_q;
                            first_d = 1'b0;
                        end else begin
                            wr_d = 1'b1;
                            addr_d = ptr_q;
                            wdat_d = sh_q;
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                ST_ACK: begin
                    if (fall && rw_q) begin
                        sh_d = link.rdata;
                        oe_d = ~link.rdata[7];
                        cnt_d = 4'h1;
                        ptr_d = ptr_q + 8'h01;
                        state_d = ST_TX;
                    end else if (fall) begin
                        oe_d = 1'b0;
                        cnt_d = 4'h0;
                        state_d = ST_WRX;
                    end
                end
                ST_TX: begin
                    if (fall && cnt_q == 4'h8) begin
                        oe_d = 1'b0;
                        state_d = ST_MACK;
                    end else if (fall) begin
                        sh_d = {sh_q[6:0], 1'b0};
                        oe_d = ~sh_q[6];
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                ST_MACK: begin
                    if (rise && !sda_s_q) begin
                        rd_d = 1'b1;
                        addr_d = ptr_q;
                        state_d = ST_ACK;
                    end else if (rise) begin
                        state_d = ST_IDLE;
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
            state_q <= ST_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            ptr_q <= 8'h00;
            oe_q <= 1'b0;
            act_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            wdat_q <= 8'h00;
            addr_q <= 8'h00;
            sda_o <= 1'b0;
        end else begin
            {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
            state_q <= state_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            rw_q <= rw_d;
            first_q <= first_d;
            ptr_q <= ptr_d;
            oe_q <= oe_d;
            act_q <= act_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            wdat_q <= wdat_d;
            addr_q <= addr_d;
            sda_o <= 1'b0;
        end
    end

    assign sda_oe_o = oe_q;
    assign link.addr = addr_q;
    assign link.wr_stb = wr_q;
    assign link.wdata = wdat_q;
    assign link.rd_stb = rd_q;
    assign link.rd_active = act_q;

    property p_stop_unlock;
        @(posedge clk_sys_i) disable iff (!rstn_i)
        stop |=> !act_q && !oe_q;
    endproperty
    a_stop_unlock: assert property (p_stop_unlock)
        else $error("lock or drive survives a stop");

endmodule // twowire_target

// file: hw/prox_result_threshold_irq.sv
/*
 * Proximity result, threshold window, persistence filter and interrupt pin,
 * with its registers reached over the two-wire serial bus.
 * Assumes the measurement front end delivers one-cycle result pulses on the
 * system clock and that SCL and SDA arrive asynchronously.
 */
`include "prox_consts.svh"

module prox_result_threshold_irq
    import prox_pkg::*;
#(
    parameter int RES_W = 11
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic int_o,
    output logic int_oe_o,
    input wire logic meas_valid_i,
    input wire logic [RES_W-1:0] meas_raw_i,
    input wire logic meas_sat_i,
    input wire logic sat_report_en_i
);
    reg_link_if link ();

    twowire_target u_target (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .link(link)
    );

    sample_t res_q, res_d, shadow_q, shadow_d, up_q, up_d, lo_q, lo_d, comp_val;
    logic [9:0] comp_q, comp_d;
    logic sat_q, sat_d, shadow_sat_q, shadow_sat_d, pend_q, pend_d;
    logic new_q, new_d, flag_q, flag_d, mode_q, mode_d, pol_q, pol_d;
    logic [3:0] run_q, run_d, persist_q, persist_d;
    logic [7:0] rdata_q, rdata_d;
    logic int_o_q, int_o_d, int_oe_q, int_oe_d;
    logic commit, outside, read_res;

    assign comp_val = (meas_raw_i > {1'b0, comp_q}) ? meas_raw_i - {1'b0, comp_q} : `RST_RES;
    assign commit = pend_q && !link.rd_active;
    assign outside = (shadow_q > up_q) || (shadow_q < lo_q);
    assign read_res = link.rd_stb &&
                      (link.addr == `ADDR_RES_LO || link.addr == `ADDR_RES_HI);

    always_comb begin
        shadow_d = shadow_q;
        shadow_sat_d = shadow_sat_q;
        pend_d = pend_q && !commit;
        res_d = res_q;
        sat_d = sat_q;
        new_d = new_q;
        flag_d = flag_q;
        run_d = run_q;
        if (meas_valid_i) begin
            shadow_d = comp_val;
            shadow_sat_d = meas_sat_i;
            pend_d = 1'b1;
        end
        if (read_res) begin
            new_d = 1'b0;
        end
        if (commit) begin
            res_d = shadow_q;
            sat_d = shadow_sat_q;
            new_d = 1'b1;
            if (outside) begin
                run_d = (run_q == `RUN_MAX) ? `RUN_MAX : run_q + 4'h1;
                if (run_q >= persist_q) begin
                    flag_d = 1'b1;
                end
            end else begin
                run_d = 4'h0;
                flag_d = 1'b0;
            end
        end
    end

    always_comb begin
        up_d = up_q;
        lo_d = lo_q;
        comp_d = comp_q;
        mode_d = mode_q;
        pol_d = pol_q;
        persist_d = persist_q;
        if (link.wr_stb) begin
            case (link.addr)
                `ADDR_IRQ_CTL: begin
                    mode_d = link.wdata[`BIT_MODE];
                    pol_d = link.wdata[`BIT_POL];
                end
                `ADDR_UP_LO: up_d = {up_q[10:8], link.wdata};
                `ADDR_UP_HI: up_d = {link.wdata[2:0], up_q[7:0]};
                `ADDR_LO_LO: lo_d = {lo_q[10:8], link.wdata};
                `ADDR_LO_HI: lo_d = {link.wdata[2:0], lo_q[7:0]};
                `ADDR_COMP_HI: comp_d = {link.wdata[1:0], comp_q[7:0]};
                `ADDR_COMP_LO: comp_d = {comp_q[9:8], link.wdata};
                `ADDR_FILTER: persist_d = link.wdata[7:4];
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (link.rd_stb) begin
            rdata_d = 8'h00;
            case (link.addr)
                `ADDR_FLAGS: rdata_d = {6'h00, flag_q, new_q};
                `ADDR_RES_LO: rdata_d = res_q[7:0];
                `ADDR_RES_HI: rdata_d = {sat_q && sat_report_en_i, 4'h0, res_q[10:8]};
                `ADDR_IRQ_CTL: rdata_d = {5'h00, pol_q, 1'b0, mode_q};
                `ADDR_UP_LO: rdata_d = up_q[7:0];
                `ADDR_UP_HI: rdata_d = {5'h00, up_q[10:8]};
                `ADDR_LO_LO: rdata_d = lo_q[7:0];
                `ADDR_LO_HI: rdata_d = {5'h00, lo_q[10:8]};
                `ADDR_COMP_HI: rdata_d = {6'h00, comp_q[9:8]};
                `ADDR_COMP_LO: rdata_d = comp_q[7:0];
                `ADDR_FILTER: rdata_d = {persist_q, 4'h0};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_comb begin
        int_oe_d = mode_q && flag_q;
        int_o_d = int_oe_d ? pol_q : 1'b0;
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shadow_q <= `RST_RES;
            shadow_sat_q <= 1'b0;
            pend_q <= 1'b0;
            res_q <= `RST_RES;
            sat_q <= 1'b0;
            new_q <= 1'b0;
            flag_q <= 1'b0;
            run_q <= 4'h0;
            up_q <= `RST_UP;
            lo_q <= `RST_LO;
            comp_q <= `RST_COMP;
            mode_q <= 1'b0;
            pol_q <= 1'b0;
            persist_q <= `RST_FILTER;
            rdata_q <= 8'h00;
            int_o_q <= 1'b0;
            int_oe_q <= 1'b0;
        end else begin
            shadow_q <= shadow_d;
            shadow_sat_q <= shadow_sat_d;
            pend_q <= pend_d;
            res_q <= res_d;
            sat_q <= sat_d;
            new_q <= new_d;
            flag_q <= flag_d;
            run_q <= run_d;
            up_q <= up_d;
            lo_q <= lo_d;
            comp_q <= comp_d;
            mode_q <= mode_d;
            pol_q <= pol_d;
            persist_q <= persist_d;
            rdata_q <= rdata_d;
            int_o_q <= int_o_d;
            int_oe_q <= int_oe_d;
        end
    end

    assign link.rdata = rdata_q;
    assign int_o = int_o_q;
    assign int_oe_o = int_oe_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_commit;
        pend_q && !link.rd_active;
    endsequence
    sequence s_out_short;
        s_commit ##0 (outside && run_q < persist_q && !flag_q);
    endsequence

    property p_new_set;
        s_commit |=> new_q ##0 (res_q == $past(shadow_q));
    endproperty
    a_new_set: assert property (p_new_set)
        else $error("commit did not raise new flag");

    property p_new_clr;
        (read_res && !commit) |=> !new_q;
    endproperty
    a_new_clr: assert property (p_new_clr)
        else $error("result read left new flag set");

    property p_lock;
        link.rd_active |=> $stable(res_q) && $stable(sat_q);
    endproperty
    a_lock: assert property (p_lock)
        else $error("result changed during a read");

    property p_shadow_kept;
        (meas_valid_i && link.rd_active) |=> pend_q && shadow_q == $past(comp_val);
    endproperty
    a_shadow_kept: assert property (p_shadow_kept)
        else $error("measurement during read was lost");

    property p_sat_gate;
        (link.rd_stb && link.addr == `ADDR_RES_HI && !sat_report_en_i) |=> !rdata_q[7];
    endproperty
    a_sat_gate: assert property (p_sat_gate)
        else $error("saturation shown while reporting disabled");

    property p_pin_off;
        !mode_q |=> !int_oe_o;
    endproperty
    a_pin_off: assert property (p_pin_off)
        else $error("pin driven with mode off");

    property p_pin_level;
        (mode_q && flag_q) |=> int_oe_o && (int_o == $past(pol_q));
    endproperty
    a_pin_level: assert property (p_pin_level)
        else $error("pin not at selected active level");

    property p_inside;
        (s_commit ##0 !outside) |=> !flag_q && run_q == 4'h0;
    endproperty
    a_inside: assert property (p_inside)
        else $error("inside result left interrupt flagged");

    property p_persist_met;
        (s_commit ##0 (outside && run_q >= persist_q)) |=> flag_q;
    endproperty
    a_persist_met: assert property (p_persist_met)
        else $error("persistence met but no flag");

    property p_persist_short;
        s_out_short |=> !flag_q;
    endproperty
    a_persist_short: assert property (p_persist_short)
        else $error("flag raised before persistence count");

endmodule // prox_result_threshold_irq

// file: verification/serial_host_model.sv
/*
 * Two-wire bus host model: register writes, grouped reads and address probes.
 * Assumes the bench resolves SDA with a pull-up and SCL needs no other driver.
 */
`include "prox_consts.svh"

module serial_host_model (
    output logic scl_o,
    output logic sda_pull_o,
    input wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam time Q = 16ns;
    int nacks = 0;

    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end

    task automatic bit_out(input logic b);
        sda_pull_o = ~b;
        #Q scl_o = 1'b1;
        #(2*Q) scl_o = 1'b0;
        #Q;
    endtask

    task automatic bit_in(output logic b);
        sda_pull_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q b = sda_i;
        #Q scl_o = 1'b0;
        #Q;
    endtask

    task automatic start_cond();
        sda_pull_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_pull_o = 1'b1;
        #Q scl_o = 1'b0;
        #Q;
    endtask

    task automatic stop_cond();
        sda_pull_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_pull_o = 1'b0;
        #Q;
    endtask

    task automatic byte_out(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(a);
        if (a) nacks++;
    endtask

    task automatic byte_in(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(last);
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        start_cond();
        byte_out({`TARGET_ADDR, 1'b0});
        byte_out(addr);
        byte_out(data);
        stop_cond();
    endtask

    task automatic read_regs(input logic [7:0] addr, input int n, output logic [15:0] d);
        d = '0;
        start_cond();
        byte_out({`TARGET_ADDR, 1'b0});
        byte_out(addr);
        start_cond();
        byte_out({`TARGET_ADDR, 1'b1});
        for (int i = 0; i < n; i++) byte_in(i == n - 1, d[8*i+:8]);
        stop_cond();
    endtask

    task automatic addr_only(input logic [6:0] a);
        start_cond();
        byte_out({a, 1'b0});
        stop_cond();
    endtask
endmodule // serial_host_model

// file: verification/test_prox_result_threshold_irq.sv
/*
 * Self-checking bench for the proximity result block, driven through a bus host.
 * Assumes the host model and the design files are compiled before it.
 */
`include "prox_consts.svh"

module test_prox_result_threshold_irq;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, rstn, meas_valid, meas_sat, sat_en, sda_o, sda_oe, int_pin, int_oe;
    logic [10:0] meas_raw;
    wire scl, host_pull, sda;
    int miscompares = 0;
    int check_count = 0;

    prox_result_threshold_irq DUT (
        .clk_sys_i(clk_sys), .rstn_i(rstn), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .int_o(int_pin), .int_oe_o(int_oe),
        .meas_valid_i(meas_valid), .meas_raw_i(meas_raw), .meas_sat_i(meas_sat),
        .sat_report_en_i(sat_en)
    );
    serial_host_model host (.scl_o(scl), .sda_pull_o(host_pull), .sda_i(sda));
    assign sda = (sda_oe ? sda_o : 1'b1) & ~host_pull;

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [15:0] w;
        host.read_regs(a, 1, w);
        chk8(what, exp, w[7:0]);
    endtask

    task automatic meas(input logic [10:0] raw, input logic sat);
        @(posedge clk_sys);
        meas_valid <= 1'b1;
        meas_raw <= raw;
        meas_sat <= sat;
        @(posedge clk_sys);
        meas_valid <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic t_regs();
        logic [7:0] tab [12][3] = '{'{8'h80, 8'h00, 8'h00}, '{8'h8c, 8'h00, 8'h00},
            '{8'h8d, 8'h00, 8'h00}, '{8'h8e, 8'h00, 8'h00}, '{8'h8f, 8'h00, 8'h05},
            '{8'h90, 8'hff, 8'hff}, '{8'h91, 8'h07, 8'h07}, '{8'h92, 8'h00, 8'hff},
            '{8'h93, 8'h00, 8'h07}, '{8'h94, 8'h00, 8'h03}, '{8'h95, 8'h00, 8'hff},
            '{8'h9e, 8'h00, 8'hf0}};
        for (int i = 0; i < 12; i++) begin
            rd_chk("reset value", tab[i][0], tab[i][1]);
            host.write_reg(tab[i][0], 8'hff);
            rd_chk("masked value", tab[i][0], tab[i][2]);
            host.write_reg(tab[i][0], tab[i][1]);
        end
        host.addr_only(7'h24);
        chk8("refused count", 8'h01, 8'(host.nacks));
        $display("test registers done");
    endtask

    task automatic t_offset_lock();
        logic [15:0] w;
        host.write_reg(`ADDR_COMP_HI, 8'h01);
        host.write_reg(`ADDR_COMP_LO, 8'h05);
        meas(11'h30a, 1'b0);
        rd_chk("flags fresh", `ADDR_FLAGS, 8'h01);
        host.read_regs(`ADDR_RES_LO, 2, w);
        chk8("result low", 8'h05, w[7:0]);
        chk8("result high", 8'h02, w[15:8]);
        rd_chk("flags read", `ADDR_FLAGS, 8'h00);
        fork
            host.read_regs(`ADDR_RES_LO, 2, w);
            begin
                #2100ns;
                meas(11'h6ff, 1'b0);
            end
        join
        chk8("locked low", 8'h05, w[7:0]);
        chk8("locked high", 8'h02, w[15:8]);
        rd_chk("flags unlocked", `ADDR_FLAGS, 8'h01);
        host.read_regs(`ADDR_RES_LO, 2, w);
        chk8("shadow low", 8'hfa, w[7:0]);
        chk8("shadow high", 8'h05, w[15:8]);
        meas(11'h003, 1'b0);
        rd_chk("floored low", `ADDR_RES_LO, 8'h00);
        host.write_reg(`ADDR_COMP_HI, 8'h00);
        host.write_reg(`ADDR_COMP_LO, 8'h00);
        $display("test offset and lock done");
    endtask

    task automatic t_sat();
        meas(11'h010, 1'b1);
        rd_chk("sat hidden", `ADDR_RES_HI, 8'h00);
        @(posedge clk_sys);
        sat_en <= 1'b1;
        rd_chk("sat shown", `ADDR_RES_HI, 8'h80);
        meas(11'h010, 1'b0);
        rd_chk("sat gone", `ADDR_RES_HI, 8'h00);
        $display("test saturation done");
    endtask

    task automatic t_persist();
        logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h2, 4'hf};
        // setup written before any measurement of this test.
        host.write_reg(`ADDR_LO_LO, 8'h64);
        host.write_reg(`ADDR_UP_LO, 8'hc8);
        host.write_reg(`ADDR_UP_HI, 8'h00);
        host.write_reg(`ADDR_IRQ_CTL, 8'h05);
        for (int c = 0; c < 4; c++) begin
            host.write_reg(`ADDR_FILTER, {codes[c], 4'h0});
            meas(11'd250, 1'b0);
            meas(11'd150, 1'b0);
            chk1("pin after inside", 1'b0, int_oe);
            for (int k = 0; k <= int'(codes[c]); k++) begin
                meas(11'd250, 1'b0);
                chk1("pin run", k == int'(codes[c]), int_oe);
            end
            chk1("level high", 1'b1, int_pin);
        end
        meas(11'd200, 1'b0);
        chk1("equal upper inside", 1'b0, int_oe);
        host.write_reg(`ADDR_FILTER, 8'h00);
        meas(11'd99, 1'b0);
        chk1("below lower", 1'b1, int_oe);
        host.write_reg(`ADDR_IRQ_CTL, 8'h01);
        chk1("low level drive", 1'b1, int_oe);
        chk1("low level", 1'b0, int_pin);
        host.write_reg(`ADDR_IRQ_CTL, 8'h04);
        chk1("mode off released", 1'b0, int_oe);
        rd_chk("flags mode off", `ADDR_FLAGS, 8'h03);
        meas(11'd150, 1'b0);
        rd_chk("flags cleared", `ADDR_FLAGS, 8'h01);
        $display("test window and persistence done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2.5ns clk_sys = ~clk_sys;
    end

    // The tests need about 170 us of bus traffic, so this span leaves a wide margin.
    initial begin
        #250us;
        miscompares++;
        $display("BAD watchdog expected done seen hang");
        wrap_up();
    end

    initial begin
        rstn = 1'b0;
        meas_valid = 1'b0;
        meas_raw = 11'h000;
        meas_sat = 1'b0;
        sat_en = 1'b0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (8) @(posedge clk_sys);
        t_regs();
        t_offset_lock();
        t_sat();
        t_persist();
        wrap_up();
    end
endmodule // test_prox_result_threshold_irq
